// >>> src/drive_defines.svh
`ifndef DRIVE_DEFINES_SVH
`define DRIVE_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define STEP_MIN_MS 5'h0E
`define GATE_MS 7'h64
`define GATE_SCALE 16'h000A
// ----------------------------------------
// scaling
// ----------------------------------------
`define PER_MILLE 16'h03E8
`define PCT_DIV 24'h000064
`define FREQ_MAX 16'hFFFF
// ----------------------------------------
// function codes
// ----------------------------------------
`define FUNC_NONE 4'h0
`define FUNC_REF 4'h1
`define FUNC_FB 4'h2
`define FUNC_WOBBLE 4'hA
`define REF_EXT_PRESET 2'h2
`define SETUP_DEFAULT 2'h0
// ----------------------------------------
// digital input positions
// ----------------------------------------
`define DI_HOLD_REF 0
`define DI_HOLD_OUT 1
`define DI_STEP_UP 2
`define DI_STEP_DOWN 3
`define DI_BOOST 4
`define DI_CUT 5
`define DI_RAMP2 6
`define DI_PRESET_LSB 7
`define DI_PRESET_MSB 8
`define DI_PRESET_EN 9
`define DI_PRECISE_N 10
`define DI_SETUP_LSB 11
`define DI_SETUP_MSB 12
`define DI_RESET_START 13
`define DI_COAST_N 14
`define DI_QUICK_N 15
`define DI_DC_N 16
`define DI_STOP_N 17
`define DI_TRACK_A 18
`define DI_TRACK_B 19
`define DI_COUNT 20
`endif

// >>> src/drive_pkg.sv
package drive_pkg;
    typedef enum logic [1:0] {PULSE_OFF, PULSE_REF, PULSE_FB, PULSE_COUNT} pulse_mode_t;
    typedef enum logic [1:0] {STEP_IDLE, STEP_HIGH, STEP_LOW} step_phase_t;
    typedef struct packed {
        logic [15:0] ms_cnt;
        logic restored;
        logic prev_hold_out;
        logic prev_hold_ref;
        logic prev_rst_start;
        step_phase_t phase;
        logic [4:0] lvl_cnt;
        logic down_seen;
        logic [15:0] held_ref;
        logic [15:0] held_freq;
        logic [6:0] gate_ms;
        logic [15:0] gate_pulses;
        logic [15:0] meas_hz;
        logic [15:0] count;
        logic count_done;
        logic [15:0] reference;
        logic [15:0] feedback;
        logic [15:0] wobble;
        logic ramp_two;
        logic stop_req;
        logic coast;
        logic quick;
        logic dc;
        logic precise;
        logic [1:0] setup;
        logic alarm_reset;
        logic run_preset;
    } top_state_t;
endpackage : drive_pkg

// >>> src/quad_if.sv
// encoder events handed from the track decoder to the decoder core
interface quad_if;
    logic step;
    logic up;
    logic rise;
    modport source (output step, output up, output rise);
    modport sink (input step, input up, input rise);
endinterface : quad_if

// >>> src/input_sync.sv
module input_sync #(
    parameter int W = 1
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;
    sync_state_t st_q;
    sync_state_t st_d;
    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    // meta is read only by the second stage
    always_comb begin
        st_d.meta = raw_in;
        st_d.stable = st_q.meta;
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign sync_out = st_q.stable;
endmodule : input_sync

// >>> src/quad_decoder.sv
module quad_decoder (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic track_a_in,
    input wire logic track_b_in,
    quad_if.source evt
);
    typedef struct packed {
        logic a;
        logic b;
        logic step;
        logic up;
        logic rise;
    } quad_state_t;
    quad_state_t st_q;
    quad_state_t st_d;
    // ----------------------------------------
    // x4 track decoding with direction
    // ----------------------------------------
    // tracks arrive already synchronised; a double change is dropped as noise
    always_comb begin
        st_d = st_q;
        st_d.a = track_a_in;
        st_d.b = track_b_in;
        st_d.step = (track_a_in ^ st_q.a) ^ (track_b_in ^ st_q.b);
        st_d.up = st_q.a ^ track_b_in;
        st_d.rise = track_a_in & ~st_q.a;
    end
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign evt.step = st_q.step;
    assign evt.up = st_q.up;
    assign evt.rise = st_q.rise;
endmodule : quad_decoder

// >>> src/drive_input_function_decoder.sv
`include "drive_defines.svh"
// Function
// - output hold latches present output frequency; only steps change it
// - under output hold only coast, quick stop or dc brake stop the motor; precise stop (pin or count) still passes under hold
// - step inputs act only in reference hold or output hold
// - up raises, down or both lowers, neither leaves the held value
// - step-driven frequency changes use the second ramp
// - step pulse needs 14 ms high then 14 ms low; 0.1 unit per step
// - held reference adjustable when stopped and restored after power loss
// - boost adds, cut removes a percentage; cut wins over boost
// - ramp select low picks ramp one, high picks ramp two
// - two preset bits, upper bit high input, pick preset one to four
// - preset enable chooses preset over remote when function code is 2
// - inverted precise stop low ramps down using the selected ramp
// - pulse reference maps 0 Hz to minimum, maximum frequency to maximum
// - pulse feedback scales input frequency against maximum feedback frequency
// - pulse counting triggers precise stop at the programmed count
// - setup bits pick one of four setups only in multi-setup mode
// - reset-and-start clears alarm then runs to preset reference
// - encoder functions decode two tracks with direction
// - analogue function codes 0 none, 1 reference, 2 feedback, 10 wobble
// - several reference inputs are summed
// - full-scale analogue input equals the programmed wobble span
// - voltage min and max points map to minimum and maximum value
module drive_input_function_decoder #(
    parameter int unsigned MS_CYCLES = (`MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [`DI_COUNT-1:0] din_pin_in,
    input wire logic [15:0] remote_ref_in,
    input wire logic [15:0] present_freq_in,
    input wire logic [15:0] saved_ref_in,
    input wire logic [63:0] preset_ref_in,
    input wire logic [7:0] boost_pct_in,
    input wire logic [1:0] ref_function_in,
    input wire logic multisetup_in,
    input wire drive_pkg::pulse_mode_t pulse_mode_in,
    input wire logic pulse_encoder_in,
    input wire logic [15:0] pulse_max_hz_in,
    input wire logic [15:0] counter_value_in,
    input wire logic [3:0] volt_func_in,
    input wire logic [3:0] curr_func_in,
    input wire logic [15:0] volt_mv_in,
    input wire logic [15:0] volt_min_mv_in,
    input wire logic [15:0] volt_max_mv_in,
    input wire logic [15:0] curr_pm_in,
    input wire logic [15:0] oscillation_span_in,
    output logic [15:0] reference_out,
    output logic [15:0] feedback_out,
    output logic [15:0] wobble_out,
    output logic [15:0] freq_cmd_out,
    output logic freq_hold_out,
    output logic [15:0] held_ref_out,
    output logic ramp_two_out,
    output logic stop_request_out,
    output logic coast_out,
    output logic quick_stop_out,
    output logic dc_brake_out,
    output logic precise_stop_out,
    output logic [1:0] setup_sel_out,
    output logic alarm_reset_out,
    output logic run_to_preset_out,
    output logic [15:0] count_value_out
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // per-mille of a span, clipped to full scale; a zero span reads as zero
    function automatic logic [15:0] scale_pm(input logic [15:0] num, input logic [15:0] den);
        logic [31:0] q;
        q = 32'h0;
        if (den != 16'h0) begin
            q = (32'(num) * 32'(`PER_MILLE)) / 32'(den);
        end
        if (q > 32'(`PER_MILLE)) begin
            q = 32'(`PER_MILLE);
        end
        return q[15:0];
    endfunction : scale_pm

    function automatic logic [15:0] sat16(input logic [17:0] v);
        return (v > 18'(`FREQ_MAX)) ? `FREQ_MAX : v[15:0];
    endfunction : sat16

    drive_pkg::top_state_t st_q;
    drive_pkg::top_state_t st_d;
    logic [`DI_COUNT-1:0] din_s;
    quad_if qev ();

    input_sync #(.W(`DI_COUNT)) u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .raw_in(din_pin_in),
        .sync_out(din_s)
    );

    quad_decoder u_quad (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .track_a_in(din_s[`DI_TRACK_A]),
        .track_b_in(din_s[`DI_TRACK_B]),
        .evt(qev.source)
    );

    // ----------------------------------------
    // synchronised input aliases
    // ----------------------------------------
    logic hold_ref_s;
    logic hold_out_s;
    logic step_up_s;
    logic step_down_s;
    logic rst_start_s;
    logic [1:0] preset_idx;
    assign hold_ref_s = din_s[`DI_HOLD_REF];
    assign hold_out_s = din_s[`DI_HOLD_OUT];
    assign step_up_s = din_s[`DI_STEP_UP];
    assign step_down_s = din_s[`DI_STEP_DOWN];
    assign rst_start_s = din_s[`DI_RESET_START];
    assign preset_idx = {din_s[`DI_PRESET_MSB], din_s[`DI_PRESET_LSB]};

    // ----------------------------------------
    // millisecond timebase and step qualifier
    // ----------------------------------------
    logic ms_tick;
    logic step_act;
    logic step_fire;
    logic hold_any;
    assign ms_tick = (st_q.ms_cnt == MS_LAST);
    assign step_act = step_up_s | step_down_s;
    assign hold_any = hold_ref_s | hold_out_s;
    // the step lands when the low phase has lasted its minimum
    assign step_fire = (st_q.phase == drive_pkg::STEP_LOW) && ms_tick && !step_act
        && (st_q.lvl_cnt == `STEP_MIN_MS - 5'h01);

    // ----------------------------------------
    // analogue and pulse scaling
    // ----------------------------------------
    logic [15:0] volt_pm;
    logic [15:0] curr_pm;
    logic [15:0] pulse_pm;
    logic [15:0] wobble_pm;
    logic [15:0] preset_sel;
    logic [15:0] remote_total;
    logic [15:0] live_ref;
    logic [15:0] base_ref;
    logic [17:0] adj;
    logic [15:0] boosted;
    logic [15:0] fb_total;
    logic use_preset;
    logic pulse_ref_on;
    logic pulse_fb_on;
    logic count_on;
    logic count_inc;
    logic count_dec;
    logic rst_start_edge;

    // volts below the minimum point clip to minimum, a reversed span reads zero
    assign volt_pm = scale_pm((volt_mv_in > volt_min_mv_in) ? volt_mv_in - volt_min_mv_in : 16'h0,
        (volt_max_mv_in > volt_min_mv_in) ? volt_max_mv_in - volt_min_mv_in : 16'h0);
    assign curr_pm = (curr_pm_in > `PER_MILLE) ? `PER_MILLE : curr_pm_in;
    assign pulse_ref_on = (pulse_mode_in == drive_pkg::PULSE_REF);
    assign pulse_fb_on = (pulse_mode_in == drive_pkg::PULSE_FB);
    assign count_on = (pulse_mode_in == drive_pkg::PULSE_COUNT);
    // 0 Hz is minimum, the programmed maximum is full scale
    assign pulse_pm = scale_pm(st_q.meas_hz, pulse_max_hz_in);
    assign remote_total = sat16(18'(remote_ref_in)
        + ((volt_func_in == `FUNC_REF) ? 18'(volt_pm) : 18'h0)
        + ((curr_func_in == `FUNC_REF) ? 18'(curr_pm) : 18'h0)
        + (pulse_ref_on ? 18'(pulse_pm) : 18'h0));
    assign fb_total = sat16(((volt_func_in == `FUNC_FB) ? 18'(volt_pm) : 18'h0)
        + ((curr_func_in == `FUNC_FB) ? 18'(curr_pm) : 18'h0)
        + (pulse_fb_on ? 18'(pulse_pm) : 18'h0));
    assign wobble_pm = (volt_func_in == `FUNC_WOBBLE) ? volt_pm
        : (curr_func_in == `FUNC_WOBBLE) ? curr_pm : 16'h0;
    assign preset_sel = preset_ref_in[16*preset_idx +: 16];
    assign rst_start_edge = rst_start_s & ~st_q.prev_rst_start;
    // reset-and-start also forces the preset so the run-up heads there
    assign use_preset = ((ref_function_in == `REF_EXT_PRESET) && din_s[`DI_PRESET_EN])
        || rst_start_s;
    assign live_ref = use_preset ? preset_sel : remote_total;
    assign base_ref = hold_ref_s ? st_q.held_ref : live_ref;
    assign adj = 18'((24'(base_ref) * 24'(boost_pct_in)) / `PCT_DIV);
    // cut is tested first, so both high reduces
    assign boosted = din_s[`DI_CUT] ? ((18'(base_ref) > adj) ? base_ref - adj[15:0] : 16'h0)
        : din_s[`DI_BOOST] ? sat16(18'(base_ref) + adj) : base_ref;
    // plain pulses count up; encoder tracks count with direction
    assign count_inc = count_on && (pulse_encoder_in ? (qev.step && qev.up) : qev.rise);
    assign count_dec = count_on && pulse_encoder_in && qev.step && !qev.up;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ms_cnt = ms_tick ? 16'h0 : st_q.ms_cnt + 16'h1;
        st_d.prev_hold_out = hold_out_s;
        st_d.prev_rst_start = rst_start_s;
        // restore waits one millisecond so the synchroniser has settled
        if (ms_tick && !st_q.restored) begin
            st_d.restored = 1'b1;
            st_d.held_ref = saved_ref_in;
        end
        if (st_q.restored) begin
            st_d.prev_hold_ref = hold_ref_s;
            if (hold_ref_s && !st_q.prev_hold_ref) begin
                st_d.held_ref = live_ref;
            end
        end
        if (hold_out_s && !st_q.prev_hold_out) begin
            st_d.held_freq = present_freq_in;
        end
        // step pulse qualifier; both inputs high count as down
        case (st_q.phase)
            drive_pkg::STEP_IDLE: begin
                if (step_act) begin
                    st_d.phase = drive_pkg::STEP_HIGH;
                    st_d.lvl_cnt = 5'h0;
                    st_d.down_seen = step_down_s;
                end
            end
            drive_pkg::STEP_HIGH: begin
                if (step_down_s) begin
                    st_d.down_seen = 1'b1;
                end
                if (!step_act) begin
                    st_d.phase = (st_q.lvl_cnt >= `STEP_MIN_MS) ? drive_pkg::STEP_LOW
                        : drive_pkg::STEP_IDLE;
                    st_d.lvl_cnt = 5'h0;
                end else if (ms_tick && st_q.lvl_cnt != 5'h1F) begin
                    st_d.lvl_cnt = st_q.lvl_cnt + 5'h1;
                end
            end
            drive_pkg::STEP_LOW: begin
                if (step_act) begin
                    // a short break voids the pulse; the new high starts over
                    st_d.phase = drive_pkg::STEP_HIGH;
                    st_d.lvl_cnt = 5'h0;
                    st_d.down_seen = step_down_s;
                end else if (step_fire) begin
                    st_d.phase = drive_pkg::STEP_IDLE;
                end else if (ms_tick) begin
                    st_d.lvl_cnt = st_q.lvl_cnt + 5'h1;
                end
            end
            default: begin
                st_d.phase = drive_pkg::STEP_IDLE;
            end
        endcase
        // output hold takes the step when both holds are on; works while stopped
        if (step_fire && hold_any && hold_out_s) begin
            if (st_q.down_seen) begin
                st_d.held_freq = (st_q.held_freq != 16'h0) ? st_q.held_freq - 16'h1 : 16'h0;
            end else begin
                st_d.held_freq = (st_q.held_freq != `FREQ_MAX) ? st_q.held_freq + 16'h1
                    : `FREQ_MAX;
            end
        end else if (step_fire && hold_any) begin
            if (st_q.down_seen) begin
                st_d.held_ref = (st_q.held_ref != 16'h0) ? st_q.held_ref - 16'h1 : 16'h0;
            end else begin
                st_d.held_ref = (st_q.held_ref < `PER_MILLE) ? st_q.held_ref + 16'h1
                    : st_q.held_ref;
            end
        end
        // frequency gate for pulse reference and feedback
        if (ms_tick) begin
            if (st_q.gate_ms == `GATE_MS - 7'h01) begin
                st_d.gate_ms = 7'h0;
                st_d.meas_hz = 16'(32'(st_q.gate_pulses) * 32'(`GATE_SCALE));
                st_d.gate_pulses = 16'(qev.rise);
            end else begin
                st_d.gate_ms = st_q.gate_ms + 7'h01;
            end
        end
        if (qev.rise && !(ms_tick && st_q.gate_ms == `GATE_MS - 7'h01)
            && st_q.gate_pulses != 16'hFFFF) begin
            st_d.gate_pulses = st_q.gate_pulses + 16'h1;
        end
        // pulse counter; reaching the target is sticky until leaving the mode or a reset-and-start edge
        if (!count_on || rst_start_edge) begin
            st_d.count = 16'h0;
            st_d.count_done = 1'b0;
        end else begin
            if (count_inc) begin
                st_d.count = st_q.count + 16'h1;
            end else if (count_dec) begin
                st_d.count = st_q.count - 16'h1;
            end
            if (counter_value_in != 16'h0 && st_d.count == counter_value_in) begin
                st_d.count_done = 1'b1;
            end
        end
        // registered command outputs
        st_d.reference = boosted;
        st_d.feedback = fb_total;
        st_d.wobble = 16'((32'(oscillation_span_in) * 32'(wobble_pm)) / 32'(`PER_MILLE));
        st_d.ramp_two = din_s[`DI_RAMP2] | hold_out_s;
        st_d.stop_req = !din_s[`DI_STOP_N] && !hold_out_s;
        st_d.coast = !din_s[`DI_COAST_N];
        st_d.quick = !din_s[`DI_QUICK_N];
        st_d.dc = !din_s[`DI_DC_N];
        st_d.precise = !din_s[`DI_PRECISE_N] || st_q.count_done;
        st_d.setup = multisetup_in ? {din_s[`DI_SETUP_MSB], din_s[`DI_SETUP_LSB]}
            : `SETUP_DEFAULT;
        st_d.alarm_reset = rst_start_edge;
        // run begins one cycle after the alarm clear
        st_d.run_preset = rst_start_s && st_q.prev_rst_start;
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reference_out = st_q.reference;
    assign feedback_out = st_q.feedback;
    assign wobble_out = st_q.wobble;
    assign freq_cmd_out = st_q.held_freq;
    assign freq_hold_out = hold_out_s;
    assign held_ref_out = st_q.held_ref;
    assign ramp_two_out = st_q.ramp_two;
    assign stop_request_out = st_q.stop_req;
    assign coast_out = st_q.coast;
    assign quick_stop_out = st_q.quick;
    assign dc_brake_out = st_q.dc;
    assign precise_stop_out = st_q.precise;
    assign setup_sel_out = st_q.setup;
    assign alarm_reset_out = st_q.alarm_reset;
    assign run_to_preset_out = st_q.run_preset;
    assign count_value_out = st_q.count;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    hold_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st_q.restored && !hold_ref_s && !hold_out_s |=> $stable(st_q.held_freq)
        && $stable(st_q.held_ref))
        else $error("held value moved without a hold mode");
    step_down_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        step_fire && hold_out_s && st_q.down_seen && st_q.held_freq != 16'h0
        && st_q.prev_hold_out |=> st_q.held_freq == $past(st_q.held_freq) - 16'h1)
        else $error("down step did not lower output frequency");
    step_width_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $rose(st_q.phase == drive_pkg::STEP_LOW) |-> $past(st_q.lvl_cnt) >= `STEP_MIN_MS)
        else $error("short high phase accepted");
    stop_mask_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        hold_out_s |=> !stop_request_out)
        else $error("ordinary stop honoured under output hold");
    cut_wins_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        din_s[`DI_CUT] |=> reference_out <= $past(base_ref))
        else $error("cut input raised the reference");
    ramp_pick_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !din_s[`DI_RAMP2] && !hold_out_s ##1 din_s[`DI_RAMP2] |=> ramp_two_out)
        else $error("ramp two not selected");
    preset_pick_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        use_preset && !hold_ref_s && !din_s[`DI_CUT] && !din_s[`DI_BOOST]
        |=> reference_out == $past(preset_sel))
        else $error("preset reference not applied");
    setup_gate_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !multisetup_in |=> setup_sel_out == `SETUP_DEFAULT)
        else $error("setup changed outside multi-setup");
    count_stop_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st_q.count_done |=> precise_stop_out)
        else $error("count target did not stop");
    alarm_first_a: assert property (@(posedge clock_in) disable iff (!resetn_in)
        $rose(run_to_preset_out) |-> $past(alarm_reset_out))
        else $error("run began before alarm clear");
endmodule : drive_input_function_decoder

// >>> verification/field_equipment.sv
// switches on the control pins, levels held until changed
module field_equipment (
    input wire logic clock_in,
    output logic [19:0] pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // inverted stop pins idle high so nothing stops the motor
    initial pins_out = 20'h3C400;
    task automatic set_pin(input int idx, input logic v);
        @(negedge clock_in);
        pins_out[idx] = v;
    endtask : set_pin
    // all pins of a mask rise and fall together
    task automatic pulse(input logic [19:0] m, input int hi, input int lo, input int ms);
        @(negedge clock_in);
        pins_out = pins_out | m;
        repeat (hi * ms) @(negedge clock_in);
        pins_out = pins_out & ~m;
        repeat (lo * ms) @(negedge clock_in);
    endtask : pulse
endmodule : field_equipment

// >>> verification/drive_input_function_decoder_test.sv
module drive_input_function_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] remote, pfreq, saved, vmv, vmin, vmax, cpm, span, ef, pmax, tgt, cnt_o;
    drive_pkg::pulse_mode_t pm;
    logic [63:0] presets;
    logic [7:0] pct;
    logic [3:0] vf, cf;
    logic mset;
    logic [19:0] pins;
    logic [15:0] ref_o, fb_o, wob_o, freq_o, href_o;
    logic r2_o, stop_o, coast_o, pr_o, alr_o, run_o, qs_o, dc_o, fh_o, enc;
    logic [1:0] set_o, rf;
    int fail_count = 0, total_checks = 0, cycles = 0, e;
    // short millisecond keeps the 14 ms qualification quick
    initial forever #10 clock_in = ~clock_in;
    field_equipment fe (.clock_in(clock_in), .pins_out(pins));
    drive_input_function_decoder #(.MS_CYCLES(MS)) dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .din_pin_in(pins),
        .remote_ref_in(remote), .present_freq_in(pfreq), .saved_ref_in(saved),
        .preset_ref_in(presets), .boost_pct_in(pct), .ref_function_in(rf),
        .multisetup_in(mset), .pulse_mode_in(pm), .pulse_encoder_in(enc),
        .pulse_max_hz_in(pmax), .counter_value_in(tgt), .volt_func_in(vf),
        .curr_func_in(cf), .volt_mv_in(vmv), .volt_min_mv_in(vmin), .volt_max_mv_in(vmax),
        .curr_pm_in(cpm), .oscillation_span_in(span), .reference_out(ref_o),
        .feedback_out(fb_o), .wobble_out(wob_o), .freq_cmd_out(freq_o), .freq_hold_out(fh_o),
        .held_ref_out(href_o), .ramp_two_out(r2_o), .stop_request_out(stop_o),
        .coast_out(coast_o), .quick_stop_out(qs_o), .dc_brake_out(dc_o), .precise_stop_out(pr_o),
        .setup_sel_out(set_o), .alarm_reset_out(alr_o), .run_to_preset_out(run_o),
        .count_value_out(cnt_o));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic wt(input int n);
        repeat (n) @(negedge clock_in);
    endtask : wt
    // a hang is cut short well past the expected run length
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        e = $urandom(46234);
        remote = 16'd500; pfreq = 16'($urandom % 1000 + 10); saved = 16'd321;
        presets = {$urandom, $urandom}; pct = 8'h00; mset = 1'b0; vf = 4'h0; cf = 4'h0;
        rf = 2'h2; pm = drive_pkg::PULSE_OFF; enc = 1'b0; pmax = 16'h0000; tgt = 16'h0000;
        // input timeout is not in use, so the minimum may sit at zero volts
        vmv = 16'h0000; vmin = 16'h0000; vmax = 16'd10000; cpm = 16'h0000; span = 16'h0000;
        wt(10); resetn_in = 1'b1; wt(20);
        check(href_o, saved);
        fe.pulse(20'h4, 15, 15, MS); wt(5);
        check(href_o, saved);
        fe.set_pin(1, 1'b1); wt(5); ef = pfreq; pfreq = pfreq + 16'd7; wt(5);
        check(freq_o, ef);
        check(16'(r2_o), 16'h0001);
        check(16'(fh_o), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            fe.pulse((i == 0) ? 20'h4 : ((i == 1) ? 20'h8 : 20'hC), 15, 15, MS); wt(5);
            ef = (i == 0) ? ef + 16'h1 : ef - 16'h1;
            check(freq_o, ef);
        end
        fe.pulse(20'h4, 10, 15, MS); wt(5);
        check(freq_o, ef);
        for (int i = 14; i < 18; i++) fe.set_pin(i, 1'b0);
        wt(5);
        check(16'(stop_o), 16'h0000);
        check(16'(coast_o), 16'h0001);
        check(16'(qs_o), 16'h0001);
        check(16'(dc_o), 16'h0001);
        for (int i = 14; i < 17; i++) fe.set_pin(i, 1'b1);
        fe.set_pin(1, 1'b0); wt(5);
        check(16'(stop_o), 16'h0001);
        fe.set_pin(17, 1'b1);
        fe.set_pin(0, 1'b1); wt(5); fe.pulse(20'h4, 15, 15, MS); wt(5);
        check(href_o, remote + 16'h1);
        fe.set_pin(0, 1'b0); pct = 8'($urandom % 50); wt(5);
        for (int i = 0; i < 4; i++) begin
            fe.set_pin(4, i[0]); fe.set_pin(5, i[1]); wt(5);
            e = i[1] ? 500 - 5 * pct : (i[0] ? 500 + 5 * pct : 500);
            check(ref_o, 16'(e));
        end
        fe.set_pin(4, 1'b0); fe.set_pin(5, 1'b0); pct = 8'h00;
        // preset index walks all four codes, ramp both levels, setup codes 2 and 3 in multi-setup
        for (int i = 0; i < 4; i++) begin
            mset = i[1]; fe.set_pin(6, i[0]); fe.set_pin(7, i[0]); fe.set_pin(8, i[1]);
            fe.set_pin(9, 1'b1); fe.set_pin(11, i[0]); fe.set_pin(12, i[1]); wt(5);
            check(ref_o, presets[16*i+:16]);
            check(16'(r2_o), 16'(i[0]));
            check(16'(set_o), mset ? 16'(i) : 16'h0000);
        end
        rf = 2'h1; wt(5);
        check(ref_o, 16'd500);
        fe.set_pin(9, 1'b0); fe.set_pin(10, 1'b0); wt(5);
        check(16'(pr_o), 16'h0001);
        fe.set_pin(10, 1'b1); fe.set_pin(13, 1'b1); e = 0;
        repeat (6) begin
            wt(1);
            e += int'(alr_o);
        end
        check(16'(e), 16'h0001);
        check({15'h0000, run_o}, 16'h0001);
        check(ref_o, presets[63:48]);
        fe.set_pin(13, 1'b0); remote = 16'd200; vf = 4'h1; vmv = 16'd5000;
        cf = 4'hA; cpm = 16'd500; span = 16'd200; wt(5);
        check(ref_o, 16'd700);
        check(wob_o, 16'd100);
        vf = 4'h2; wt(5);
        check(fb_o, 16'd500);
        // tracks walked with B leading count up, one count per edge
        pm = drive_pkg::PULSE_COUNT; enc = 1'b1; tgt = 16'h0008;
        for (int i = 0; i < 8; i++) fe.set_pin(i[0] ? 18 : 19, !i[1]);
        wt(5);
        check(cnt_o, 16'h0008);
        check(16'(pr_o), 16'h0001);
        fe.set_pin(18, 1'b1); wt(5);
        check(cnt_o, 16'h0007);
        check(16'(pr_o), 16'h0001);
        // a 50-cycle period puts exactly 20 rises in every 1000-cycle gate
        pm = drive_pkg::PULSE_FB; pmax = 16'd400;
        for (int i = 0; i < 50; i++) begin
            fe.pulse(20'h40000, 10, 39, 1);
            if (i == 45) begin
                check(fb_o, 16'd1000);
                pm = drive_pkg::PULSE_REF;
            end
        end
        check(ref_o, 16'd700);
        test_done();
    end
endmodule : drive_input_function_decoder_test
